// [src/rta_pkg.sv]
// package: offsets, fields, resets and carriers of the resistance limit block
package rta_pkg;
    localparam logic [7:0] ADDR_ALT_CFG = 8'h05;
    localparam logic [7:0] ADDR_UPPER_LOW = 8'h06;
    localparam logic [7:0] ADDR_UPPER_HIGH = 8'h07;
    localparam logic [7:0] ADDR_LOWER_LOW = 8'h08;
    localparam logic [7:0] ADDR_LOWER_HIGH = 8'h09;
    localparam int ALT_INDUCT_ONLY_BIT = 0;
    localparam int ALT_POWER_OFF_BIT = 1;
    localparam logic [7:0] ALT_CFG_RESET = 8'h00;
    localparam logic [7:0] LIMIT_BYTE_RESET = 8'h00;
    localparam logic [1:0] STATE_ACTIVE = 2'h0;
    localparam logic [1:0] STATE_SLEEP = 2'h1;
    localparam logic [1:0] STATE_POWER_OFF = 2'h2;
    localparam logic [5:0] ALERT_UPPER_LATCH = 6'h01;
    localparam logic [5:0] ALERT_HYSTERESIS = 6'h02;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rta_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } rta_result_t;
endpackage

// [src/rta_core.sv]
// resistance limit pairs, alternate drive config and limit comparison
`timescale 1ns/100ps
module rta_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire rta_pkg::rta_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire rta_pkg::rta_result_t res_in,
    input wire logic [1:0] operating_state_select,
    input wire logic [5:0] alert_source_select,
    input wire logic alert_clear,
    output logic power_off_allowed,
    output logic resistance_enable,
    output logic inductance_enable,
    output logic high_res_inductance_enable,
    output logic resistance_valid,
    output logic above_upper_flag,
    output logic below_lower_flag,
    output logic alert_out
);
    import rta_pkg::*;

    // ---------------------------------------------------------------
    // pair indices
    // ---------------------------------------------------------------
    localparam int NPAIR = 2;
    localparam int UP = 0;
    localparam int LO = 1;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // write strobe aimed at one offset
    function automatic logic hit(input rta_reg_req_t r,
                                 input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // offset match for the read-back select
    function automatic logic look(input rta_reg_req_t r,
                                  input logic [7:0] a);
        look = (r.addr == a);
    endfunction

    // ---------------------------------------------------------------
    // compare helper
    // ---------------------------------------------------------------
    // strict compare, true when a lies above b
    function automatic logic above(input logic [15:0] a,
                                   input logic [15:0] b);
        above = (a > b);
    endfunction

    // ---------------------------------------------------------------
    // alternate drive config
    // ---------------------------------------------------------------
    wire wr_alt;
    logic [7:0] alt_q;
    assign wr_alt = hit(reg_req, ADDR_ALT_CFG);

    // reserved bits kept as written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_q <= ALT_CFG_RESET;
        end else if (clk_en && wr_alt) begin
            alt_q <= reg_req.wdata;
        end
    end

    // ---------------------------------------------------------------
    // limit pairs: buffered low byte, committing high byte
    // ---------------------------------------------------------------
    logic [7:0] buf_q [NPAIR];
    logic [15:0] limit_q [NPAIR];
    logic wr_low [NPAIR];
    logic wr_high [NPAIR];

    genvar g;
    generate
        for (g = 0; g < NPAIR; g++) begin : g_pair
            localparam logic [7:0] LOW_ADDR =
                (g == UP) ? ADDR_UPPER_LOW : ADDR_LOWER_LOW;
            localparam logic [7:0] HIGH_ADDR =
                (g == UP) ? ADDR_UPPER_HIGH : ADDR_LOWER_HIGH;

            assign wr_low[g] = hit(reg_req, LOW_ADDR);
            assign wr_high[g] = hit(reg_req, HIGH_ADDR);

            // low byte waits here for its high byte
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    buf_q[g] <= LIMIT_BYTE_RESET;
                end else if (clk_en && wr_low[g]) begin
                    buf_q[g] <= reg_req.wdata;
                end
            end

            // high write commits both bytes at once, in any state
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    limit_q[g] <= {LIMIT_BYTE_RESET, LIMIT_BYTE_RESET};
                end else if (clk_en && wr_high[g]) begin
                    limit_q[g] <= {reg_req.wdata, buf_q[g]};
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // limit values
    // ---------------------------------------------------------------
    wire [15:0] upper_lim;
    wire [15:0] lower_lim;
    assign upper_lim = limit_q[UP];
    assign lower_lim = limit_q[LO];

    // ---------------------------------------------------------------
    // read back
    // ---------------------------------------------------------------
    wire rd_alt;
    wire rd_up_lo;
    wire rd_up_hi;
    wire rd_lo_lo;
    wire rd_lo_hi;
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    assign rd_alt = look(reg_req, ADDR_ALT_CFG);
    assign rd_up_lo = look(reg_req, ADDR_UPPER_LOW);
    assign rd_up_hi = look(reg_req, ADDR_UPPER_HIGH);
    assign rd_lo_lo = look(reg_req, ADDR_LOWER_LOW);
    assign rd_lo_hi = look(reg_req, ADDR_LOWER_HIGH);

    // unmapped offsets read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (rd_alt) begin
            rd_mux = alt_q;
        end
        if (rd_up_lo) begin
            rd_mux = buf_q[UP];
        end
        if (rd_up_hi) begin
            rd_mux = upper_lim[15:8];
        end
        if (rd_lo_lo) begin
            rd_mux = buf_q[LO];
        end
        if (rd_lo_hi) begin
            rd_mux = lower_lim[15:8];
        end
    end

    // ---------------------------------------------------------------
    // read data register
    // ---------------------------------------------------------------
    // read data stands until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (clk_en && reg_req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // drive mode
    // ---------------------------------------------------------------
    wire induct_only;
    wire converting;
    assign induct_only = alt_q[ALT_INDUCT_ONLY_BIT];
    assign converting = (operating_state_select == STATE_ACTIVE);

    assign resistance_enable = converting && !induct_only;
    assign inductance_enable = converting;
    assign high_res_inductance_enable = converting;
    assign resistance_valid = !induct_only;

    // ---------------------------------------------------------------
    // power-off permit
    // ---------------------------------------------------------------
    wire permit;
    wire off_req;
    assign permit = alt_q[ALT_POWER_OFF_BIT];
    assign off_req = (operating_state_select == STATE_POWER_OFF);

    // power-off request without permit is dropped
    assign power_off_allowed = permit && off_req;

    // ---------------------------------------------------------------
    // comparison, one update per accepted result
    // ---------------------------------------------------------------
    wire res_take;
    wire cmp_above;
    wire cmp_below;
    logic above_q;
    logic below_q;
    assign res_take = res_in.valid && resistance_enable;
    assign cmp_above = above(res_in.value, upper_lim);
    assign cmp_below = above(lower_lim, res_in.value);

    // ---------------------------------------------------------------
    // upper flag
    // ---------------------------------------------------------------
    // a limit committed with the result applies from the next one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            above_q <= 1'b0;
        end else if (clk_en && res_take) begin
            above_q <= cmp_above;
        end
    end

    // ---------------------------------------------------------------
    // lower flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            below_q <= 1'b0;
        end else if (clk_en && res_take) begin
            below_q <= cmp_below;
        end
    end

    assign above_upper_flag = above_q;
    assign below_lower_flag = below_q;

    // ---------------------------------------------------------------
    // latching compare
    // ---------------------------------------------------------------
    wire sel_latch;
    wire sel_hyst;
    logic latch_d;
    logic hyst_d;
    logic alert_d;
    logic alert_q;
    assign sel_latch = (alert_source_select == ALERT_UPPER_LATCH);
    assign sel_hyst = (alert_source_select == ALERT_HYSTERESIS);

    // a new crossing wins over a clear in the same cycle
    always_comb begin
        latch_d = alert_q;
        if (res_take && cmp_above) begin
            latch_d = 1'b1;
        end else if (alert_clear) begin
            latch_d = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // hysteresis compare
    // ---------------------------------------------------------------
    // set above upper, clear below lower, else hold
    always_comb begin
        hyst_d = alert_q;
        if (res_take && cmp_above) begin
            hyst_d = 1'b1;
        end else if (res_take && cmp_below) begin
            hyst_d = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // alert select and register
    // ---------------------------------------------------------------
    // any other select code keeps the alert low
    always_comb begin
        if (sel_latch) begin
            alert_d = latch_d;
        end else if (sel_hyst) begin
            alert_d = hyst_d;
        end else begin
            alert_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_q <= 1'b0;
        end else if (clk_en) begin
            alert_q <= alert_d;
        end
    end

    assign alert_out = alert_q;
endmodule

// [verification/rta_core_sva.sv]
// checker of the resistance limit block
`timescale 1ns/100ps
module rta_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire rta_pkg::rta_result_t res_in,
    input wire logic [1:0] operating_state_select,
    input wire logic [5:0] alert_source_select,
    input wire logic power_off_allowed,
    input wire logic resistance_enable,
    input wire logic high_res_inductance_enable,
    input wire logic resistance_valid,
    input wire logic above_upper_flag,
    input wire logic below_lower_flag,
    input wire logic alert_out
);
    import rta_pkg::*;
    wire tk = clk_en && res_in.valid && resistance_enable;
    wire act = operating_state_select == STATE_ACTIVE;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence res_s(v);
        tk && res_in.value == v;
    endsequence
    power_gate_a: assert property (
        power_off_allowed |-> operating_state_select == STATE_POWER_OFF)
        else $error("power gate");
    drive_only_a: assert property (
        resistance_enable |-> resistance_valid && act) else $error("drive");
    both_kinds_a: assert property (
        resistance_valid && act |-> resistance_enable
        && high_res_inductance_enable) else $error("both kinds");
    zero_above_a: assert property (
        res_s(16'h0000) |=> !above_upper_flag) else $error("above");
    full_below_a: assert property (
        res_s(16'hFFFF) |=> !below_lower_flag) else $error("below");
    above_hold_a: assert property (
        !tk |=> $stable(above_upper_flag)) else $error("above hold");
    below_hold_a: assert property (
        !tk |=> $stable(below_lower_flag)) else $error("below hold");
    alert_off_a: assert property (
        clk_en && alert_source_select == 6'h00 |=> !alert_out)
        else $error("alert off");
endmodule
bind rta_core rta_chk chk_u (.*);

// [verification/rta_host.sv]
// host model on the register port
`timescale 1ns/100ps
module rta_host (
    input wire logic clk,
    output rta_pkg::rta_reg_req_t req
);
    initial req = '0;
    task automatic put(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic limit(input logic [7:0] a, input logic [15:0] v);
        put(1, a, v[7:0]);
        put(1, a + 8'h01, v[15:8]);
    endtask
endmodule

// [verification/test_resistance_threshold_alternate_drive_config.sv]
// bench of the resistance limit block
`timescale 1ns/100ps
module test_resistance_threshold_alternate_drive_config;
    import rta_pkg::*;
    typedef struct {logic [15:0] u, l, v; logic [1:0] f;} rta_row_t;
    logic clk = 0, rst = 1, en = 1, clr = 0;
    logic [1:0] st = STATE_ACTIVE;
    logic [5:0] asel = ALERT_UPPER_LATCH;
    rta_result_t res = '0;
    rta_reg_req_t req;
    logic [7:0] rd;
    logic pwr, ren, rval, ab, be, al;
    int err_count = 0, comparisons = 0;
    logic [5:0] codes[2] = '{ALERT_UPPER_LATCH, ALERT_HYSTERESIS};
    rta_row_t rows[6] = '{'{16'h1234, 16'h0100, 16'h1235, 2'h2},
        '{16'h1234, 16'h0100, 16'h1234, 2'h0},
        '{16'h1234, 16'h0100, 16'h0100, 2'h0},
        '{16'h1234, 16'h0100, 16'h00FF, 2'h1},
        '{16'hFF00, 16'h8000, 16'hFFFF, 2'h2},
        '{16'h0000, 16'h0000, 16'h0000, 2'h0}};
    always #25 clk = ~clk;
    rta_host host_u (.clk(clk), .req(req));
    rta_core dut_u (.clk(clk), .rst(rst), .clk_en(en), .reg_req(req),
        .reg_rdata(rd), .res_in(res), .operating_state_select(st),
        .alert_source_select(asel), .alert_clear(clr),
        .power_off_allowed(pwr), .resistance_enable(ren),
        .inductance_enable(), .high_res_inductance_enable(),
        .resistance_valid(rval), .above_upper_flag(ab),
        .below_lower_flag(be), .alert_out(al));
    task automatic cmp(input logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic chkreg(input logic [7:0] a, e);
        host_u.put(0, a, 8'h00);
        #1 cmp(rd, e);
    endtask
    task automatic send(input logic [15:0] v);
        @(posedge clk);
        res <= '{1'b1, v};
        @(posedge clk);
        res <= '{1'b0, ~v};
        #1;
    endtask
    task automatic complete_run;
        $display("errors %0d of %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        for (int i = 5; i < 11; i++) chkreg(8'(i), 8'h00);
        cmp({7'h0, rval}, 8'h01);
        foreach (rows[i]) begin
            host_u.limit(ADDR_UPPER_LOW, rows[i].u);
            host_u.limit(ADDR_LOWER_LOW, rows[i].l);
            send(rows[i].v);
            cmp({6'h0, ab, be}, {6'h0, rows[i].f});
        end
        $display("rows done");
        host_u.put(1, ADDR_UPPER_HIGH, 8'h10);
        host_u.put(1, ADDR_UPPER_LOW, 8'hFF);
        send(16'h1001);
        cmp({6'h0, ab, be}, 8'h02);
        chkreg(ADDR_UPPER_LOW, 8'hFF);
        host_u.put(1, ADDR_UPPER_HIGH, 8'h10);
        send(16'h1001);
        cmp({6'h0, ab, be}, 8'h00);
        $display("pair test done");
        host_u.put(1, ADDR_ALT_CFG, 8'h01);
        send(16'h2000);
        cmp({6'h0, ab, ren}, 8'h00);
        @(posedge clk);
        st <= STATE_POWER_OFF;
        #1 cmp({7'h0, pwr}, 8'h00);
        host_u.put(1, ADDR_ALT_CFG, 8'h02);
        #1 cmp({7'h0, pwr}, 8'h01);
        @(posedge clk);
        st <= STATE_ACTIVE;
        host_u.limit(ADDR_LOWER_LOW, 16'h0800);
        $display("mode test done");
        @(posedge clk);
        en <= 1'b0;
        send(16'hFFFF);
        cmp({6'h0, ab, be}, 8'h00);
        @(posedge clk);
        en <= 1'b1;
        foreach (codes[i]) begin
            @(posedge clk);
            asel <= codes[i];
            send(16'h2000);
            send(16'h0100);
            cmp({7'h0, al}, {7'h0, i == 0});
            @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            #1 cmp({7'h0, al}, 8'h00);
        end
        @(posedge clk);
        asel <= 6'h00;
        send(16'h2000);
        cmp({7'h0, al}, 8'h00);
        $display("alert test done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1 cmp({6'h0, ab, be}, 8'h00);
        chkreg(ADDR_UPPER_HIGH, 8'h00);
        $display("reset test done");
        complete_run;
    end
endmodule
